// ### rtl/rps_map.svh
/*
 * Register offsets, field positions, reset values and pin constants
 * of the remappable pin select block.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

// Byte offsets on the register bus
`define RPS_IN_SEL_BASE     12'h000
`define RPS_OUT_SEL_BASE    12'h100
`define RPS_SYS_CFG_OFF     12'h200
`define RPS_CFG_WORD3_OFF   12'h204

// Field positions
`define RPS_SEL_MSB         3
`define RPS_MAP_LOCK_BIT    13
`define RPS_ONE_SESSION_BIT 29

// Reset values
`define RPS_OUT_SEL_RST     4'h0
`define RPS_IN_SEL_RST      4'h0
`define RPS_MAP_LOCK_RST    1'b0

// Counts and masks
`define RPS_NUM_IN          24
`define RPS_NUM_PINS        32
`define RPS_OUT_PIN_MASK    32'hFFFB_FFFB
`define RPS_IN_INACTIVE     1'b0

// Bus responses
`define RPS_RESP_OKAY       2'h0
`define RPS_RESP_SLVERR     2'h2

`endif

// ### rtl/rps_pkg.sv
/*
 * Types of the remappable pin select block: bus carriers and the
 * bundle of peripheral outputs that may be placed on pins.
 * Assumes rps_map.svh is on the include path.
 */
`default_nettype none

package rps_pkg;
	`include "rps_map.svh"

	// AXI4-Lite request, master to slave (no prot signals)
	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} rps_axil_req_t;

	// AXI4-Lite response, slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} rps_axil_rsp_t;

	// Peripheral outputs eligible for remapping
	typedef struct packed {
		logic uart1_transmit;
		logic uart2_request_to_send;
		logic spi1_slave_select;
		logic usb_vbus_power_on;
		logic compare1_output;
		logic comparator2_output;
		logic spi1_serial_out;
		logic spi2_serial_out;
		logic compare2_output;
		logic comparator3_output;
		logic compare4_output;
		logic compare5_output;
		logic reference_clock_output;
		logic uart1_request_to_send;
		logic uart2_transmit;
		logic spi2_slave_select;
		logic compare3_output;
		logic comparator1_output;
	} rps_periph_out_t;
endpackage

`default_nettype wire

// ### rtl/rps_pin_select.sv
/*
 * Remappable pin select: per-peripheral input routing, per-pin output
 * routing, map write lock with optional single-session lock, and an
 * AXI4-Lite register slave.
 * Assumes pins arrive asynchronously, peripherals, port logic and the
 * system unlock logic share clk, and the config word is stable at reset.
 */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "rps_map.svh"

module rps_pin_select
	import rps_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rstn,
	// Register bus
	input  wire rps_axil_req_t   axil_req,
	output var  rps_axil_rsp_t   axil_rsp,
	// System lock control
	input  wire logic            sys_unlocked,
	input  wire logic [31:0]     cfg_word3,
	// Peripheral side
	input  wire rps_periph_out_t periph_out,
	output logic [`RPS_NUM_IN-1:0]   periph_in,
	// Port side
	input  wire logic [`RPS_NUM_PINS-1:0] pin_in,
	input  wire logic [`RPS_NUM_PINS-1:0] gpio_out,
	input  wire logic [`RPS_NUM_PINS-1:0] gpio_oe,
	input  wire logic [`RPS_NUM_PINS-1:0] analog_sel,
	output logic [`RPS_NUM_PINS-1:0] pin_out,
	output logic [`RPS_NUM_PINS-1:0] pin_oe
);

	// Group of each peripheral input: 5, 6, 8 and 5 inputs
	function automatic logic [1:0] in_group(input int idx);
		if (idx < 5)
			return 2'd0;
		else if (idx < 11)
			return 2'd1;
		else if (idx < 19)
			return 2'd2;
		return 2'd3;
	endfunction

	// Pin for an input code; reserved codes give a fixed level
	function automatic logic in_route(input logic [31:0] pins, input logic [1:0] grp,
		input logic [3:0] code);
		if (code[3])
			return `RPS_IN_INACTIVE;
		return pins[{grp, code[2:0]}];
	endfunction

	// Peripheral for a pin output code: {connected, level}
	function automatic logic [1:0] out_route(input logic [1:0] grp, input logic [3:0] code,
		input rps_periph_out_t po);
		logic [1:0] r;
		r = 2'b00; // code 0 and reserved codes connect nothing
		unique case (grp)
			2'd0:
				unique case (code)
					4'h1: r = {1'b1, po.uart1_transmit};
					4'h2: r = {1'b1, po.uart2_request_to_send};
					4'h3: r = {1'b1, po.spi1_slave_select};
					4'h4: r = {1'b1, po.usb_vbus_power_on};
					4'h5: r = {1'b1, po.compare1_output};
					4'h7: r = {1'b1, po.comparator2_output};
					default: r = 2'b00;
				endcase
			2'd1:
				unique case (code)
					4'h3: r = {1'b1, po.spi1_serial_out};
					4'h4: r = {1'b1, po.spi2_serial_out};
					4'h5: r = {1'b1, po.compare2_output};
					4'h7: r = {1'b1, po.comparator3_output};
					default: r = 2'b00;
				endcase
			2'd2:
				unique case (code)
					4'h3: r = {1'b1, po.spi1_serial_out};
					4'h4: r = {1'b1, po.spi2_serial_out};
					4'h5: r = {1'b1, po.compare4_output};
					4'h6: r = {1'b1, po.compare5_output};
					4'h7: r = {1'b1, po.reference_clock_output};
					default: r = 2'b00;
				endcase
			2'd3:
				unique case (code)
					4'h1: r = {1'b1, po.uart1_request_to_send};
					4'h2: r = {1'b1, po.uart2_transmit};
					4'h4: r = {1'b1, po.spi2_slave_select};
					4'h5: r = {1'b1, po.compare3_output};
					4'h7: r = {1'b1, po.comparator1_output};
					default: r = 2'b00;
				endcase
		endcase
		return r;
	endfunction

	// Pins 2 and 18 have no output select and always follow the port
	function automatic logic has_out_sel(input logic [4:0] pin);
		logic [31:0] mask;
		mask = `RPS_OUT_PIN_MASK;
		return mask[pin];
	endfunction

	// Address decode shared by the write and read paths
	function automatic logic is_in_sel(input logic [11:0] a);
		return a[11:7] == 5'(`RPS_IN_SEL_BASE >> 7) && a[6:2] < 5'(`RPS_NUM_IN);
	endfunction

	// Holes in the pin block answer with an error, as unmapped space does
	function automatic logic is_out_sel(input logic [11:0] a);
		return a[11:7] == 5'(`RPS_OUT_SEL_BASE >> 7) && has_out_sel(a[6:2]);
	endfunction

	// Reset release through two flops
	logic rst_s1_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Pin synchronisers; only the second stage feeds logic
	logic [`RPS_NUM_PINS-1:0] pin_s1_q;
	logic [`RPS_NUM_PINS-1:0] pin_s2_q;

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end
		else
		begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Map storage: one code per input, one per pin
	logic [3:0] in_sel_q  [`RPS_NUM_IN];
	logic [3:0] out_sel_q [`RPS_NUM_PINS];
	logic       map_lock_q;
	logic       lock_set_once_q;
	logic       one_session_q;
	logic       cfg_taken_q;
	logic [31:0] cfg_word3_q;

	// Bus channel state
	logic        aw_have_q;
	logic        w_have_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	rps_axil_rsp_t rsp_q;

	// Write address decode
	wire        wr_fire   = aw_have_q && w_have_q && !rsp_q.bvalid;
	wire [4:0]  wr_idx    = aw_addr_q[6:2];
	wire        wr_in     = is_in_sel(aw_addr_q);
	wire        wr_out    = is_out_sel(aw_addr_q);
	wire        wr_sys    = aw_addr_q == `RPS_SYS_CFG_OFF;
	wire        wr_cfg    = aw_addr_q == `RPS_CFG_WORD3_OFF;
	wire        wr_mapped = wr_in || wr_out || wr_sys || wr_cfg;
	wire        map_open  = !map_lock_q;
	wire        sel_we    = wr_fire && w_strb_q[0] && map_open;

	// Lock bit update: needs the system unlock, one-session refuses clears
	wire lock_wr    = wr_fire && wr_sys && w_strb_q[1] && sys_unlocked;
	wire lock_new   = w_data_q[`RPS_MAP_LOCK_BIT];
	wire clr_refuse = one_session_q && lock_set_once_q && !lock_new;
	wire lock_d     = (lock_wr && !clr_refuse) ? lock_new : map_lock_q;

	// Read address decode
	wire [11:0] rd_addr = axil_req.araddr[11:0];
	wire [4:0]  rd_idx  = rd_addr[6:2];
	wire        rd_in   = is_in_sel(rd_addr);
	wire        rd_out  = is_out_sel(rd_addr);
	wire        rd_sys  = rd_addr == `RPS_SYS_CFG_OFF;
	wire        rd_cfg  = rd_addr == `RPS_CFG_WORD3_OFF;
	wire        rd_ok   = rd_in || rd_out || rd_sys || rd_cfg;
	wire [31:0] rd_data = rd_in ? {28'h000_0000, in_sel_q[rd_idx]}
		: rd_out ? {28'h000_0000, out_sel_q[rd_idx]}
		: rd_sys ? 32'(map_lock_q) << `RPS_MAP_LOCK_BIT
		: rd_cfg ? cfg_word3_q : 32'h0000_0000;
	wire        rd_take = axil_req.arvalid && rsp_q.arready;

	// Config word caught once after reset release; erased fuse reads set
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			cfg_taken_q   <= 1'b0;
			cfg_word3_q   <= 32'h0000_0000;
			one_session_q <= 1'b1; // safe side until captured
		end
		else if (!cfg_taken_q)
		begin
			cfg_taken_q   <= 1'b1;
			cfg_word3_q   <= cfg_word3;
			one_session_q <= cfg_word3[`RPS_ONE_SESSION_BIT];
		end
	end

	// Lock state; the set-once memory only clears at reset
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			map_lock_q      <= `RPS_MAP_LOCK_RST;
			lock_set_once_q <= 1'b0;
		end
		else
		begin
			map_lock_q      <= lock_d;
			lock_set_once_q <= lock_set_once_q || lock_d;
		end
	end

	// Separate tables for inputs and outputs
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			for (int i = 0; i < `RPS_NUM_IN; i++)
				in_sel_q[i] <= `RPS_IN_SEL_RST;
			for (int p = 0; p < `RPS_NUM_PINS; p++)
				out_sel_q[p] <= `RPS_OUT_SEL_RST;
		end
		else if (sel_we && wr_in)
			in_sel_q[wr_idx] <= w_data_q[`RPS_SEL_MSB:0];
		else if (sel_we && wr_out)
			out_sel_q[wr_idx] <= w_data_q[`RPS_SEL_MSB:0];
	end

	// Write channels taken in either order, answered after both
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end
		else
		begin
			if (axil_req.awvalid && rsp_q.awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {axil_req.awaddr[11:2], 2'b00};
			end
			else if (wr_fire)
				aw_have_q <= 1'b0;
			if (axil_req.wvalid && rsp_q.wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= axil_req.wdata;
				w_strb_q <= axil_req.wstrb;
			end
			else if (wr_fire)
				w_have_q <= 1'b0;
		end
	end

	// Response flops; locked writes still answer OKAY
	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			rsp_q <= '0;
		else
		begin
			rsp_q.awready <= !(aw_have_q || axil_req.awvalid && rsp_q.awready) || wr_fire;
			rsp_q.wready  <= !(w_have_q || axil_req.wvalid && rsp_q.wready) || wr_fire;
			if (wr_fire)
			begin
				rsp_q.bvalid <= 1'b1;
				rsp_q.bresp  <= wr_mapped ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
			end
			else if (axil_req.bready)
				rsp_q.bvalid <= 1'b0;
			if (rd_take)
			begin
				rsp_q.arready <= 1'b0;
				rsp_q.rvalid  <= 1'b1;
				rsp_q.rdata   <= rd_data;
				rsp_q.rresp   <= rd_ok ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
			end
			else if (rsp_q.rvalid && axil_req.rready)
			begin
				rsp_q.rvalid  <= 1'b0;
				rsp_q.arready <= 1'b1;
			end
			else if (!rsp_q.rvalid)
				rsp_q.arready <= 1'b1;
		end
	end

	assign axil_rsp = rsp_q;

	// Routing, registered so every output leaves a flop
	logic [`RPS_NUM_IN-1:0]   periph_in_q;
	logic [`RPS_NUM_PINS-1:0] pin_out_q;
	logic [`RPS_NUM_PINS-1:0] pin_oe_q;
	wire  [1:0]               out_pick [`RPS_NUM_PINS];
	wire  [`RPS_NUM_PINS-1:0] out_take;
	wire  [`RPS_NUM_PINS-1:0] pick_lvl;

	// Output choice per pin, decoded ahead of the flops
	for (genvar p = 0; p < `RPS_NUM_PINS; p++)
	begin : g_pick
		assign out_pick[p] = out_route(2'(p >> 3), out_sel_q[p], periph_out);
		// Remap wins over port logic unless the pin is analog
		assign out_take[p] = out_pick[p][1] && !analog_sel[p] && has_out_sel(5'(p));
		assign pick_lvl[p] = out_pick[p][0];
	end

	always_ff @(posedge clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			periph_in_q <= '0;
			pin_out_q   <= '0;
			pin_oe_q    <= '0;
		end
		else
		begin
			for (int i = 0; i < `RPS_NUM_IN; i++)
				periph_in_q[i] <= in_route(pin_s2_q, in_group(i), in_sel_q[i]);
			pin_out_q <= (out_take & pick_lvl) | (~out_take & gpio_out);
			pin_oe_q  <= out_take | gpio_oe;
		end
	end

	assign periph_in = periph_in_q;
	assign pin_out   = pin_out_q;
	assign pin_oe    = pin_oe_q;

endmodule

`default_nettype wire

// ### verif/rps_pin_select_checker.sv
/* Checker of the remappable pin select: bus timing and pin priority.
   Assumes a bind from the bench onto the top module's ports. */
`default_nettype none
`include "rps_map.svh"
module rps_pin_select_checker
	import rps_pkg::*;
(
	// Clock and reset
	input wire logic          clk,
	input wire logic          rstn,
	// Register bus
	input wire rps_axil_req_t axil_req,
	input wire rps_axil_rsp_t axil_rsp,
	// Pins
	input wire logic [31:0]   gpio_out,
	input wire logic [31:0]   analog_sel,
	input wire logic [31:0]   pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] up_q;
	// Settle count, as the internal reset trails rstn by two edges
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			up_q <= 2'd0;
		else if (up_q != 2'd3)
			up_q <= up_q + 2'd1;
	wire live = up_q == 2'd3;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_aw_take; axil_req.awvalid && axil_rsp.awready; endsequence
	sequence s_w_take; axil_req.wvalid && axil_rsp.wready; endsequence
	sequence s_ar_take; axil_req.arvalid && axil_rsp.arready; endsequence
	property p_aw_drop; s_aw_take |=> !axil_rsp.awready; endproperty
	property p_b_time; s_aw_take ##0 s_w_take |-> ##[1:2] axil_rsp.bvalid; endproperty
	property p_b_clear; axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid; endproperty
	property p_ar_drop; s_ar_take |=> !axil_rsp.arready; endproperty
	property p_r_time; s_ar_take |-> ##[1:2] axil_rsp.rvalid; endproperty
	property p_r_err;
		s_ar_take ##0 (axil_req.araddr == 32'h0000_0300)
			|-> ##[1:2] (axil_rsp.rvalid && axil_rsp.rresp == `RPS_RESP_SLVERR);
	endproperty
	property p_analog;
		live && analog_sel != 32'h0000_0000
			|=> ((pin_out ^ $past(gpio_out)) & $past(analog_sel)) == 32'h0000_0000;
	endproperty
	property p_fixed;
		live |=> pin_out[2] == $past(gpio_out[2]) && pin_out[18] == $past(gpio_out[18]);
	endproperty
	a_aw_drop: assert property (p_aw_drop) else $error("awready held after take");
	a_b_time: assert property (p_b_time) else $error("write answer late");
	a_b_clear: assert property (p_b_clear) else $error("bvalid held after bready");
	a_ar_drop: assert property (p_ar_drop) else $error("arready held after take");
	a_r_time: assert property (p_r_time) else $error("read answer late");
	a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
	a_analog: assert property (p_analog) else $error("remap beat analog pin");
	a_fixed: assert property (p_fixed) else $error("fixed pin not port driven");
endmodule
`default_nettype wire

// ### verif/rps_far_model.sv
/* Far side: pin wires with outside drivers, and peripheral outputs.
   Assumes the bench sets the outside levels it wants seen. */
`default_nettype none
module rps_far_model
	import rps_pkg::*;
(
	// Levels set by the bench
	input  wire logic [31:0]     ext_lvl,
	input  wire rps_periph_out_t per_lvl,
	// Block side
	input  wire logic [31:0]     pin_out,
	input  wire logic [31:0]     pin_oe,
	output logic [31:0]          pin_in,
	output rps_periph_out_t      periph_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Driven pins show the block, so outside drivers never fight it
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	assign periph_out = per_lvl;
endmodule
`default_nettype wire

// ### verif/rps_pin_select_test.sv
/* Bench of the remappable pin select, one task per scenario.
   Assumes the package, header and design compile ahead of it. */
`default_nettype none
`include "rps_map.svh"
module rps_pin_select_test
	import rps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk, rstn, sys_unlocked;
	rps_axil_req_t   req;
	rps_axil_rsp_t   rsp;
	rps_periph_out_t per, periph_out;
	logic [31:0]     cfg_word3, ext, gpio_out, gpio_oe, analog_sel, pin_in, pin_out, pin_oe;
	logic [23:0]     periph_in;
	int              mismatches, tests_run, cyc;
	// Output code to struct bit, -1 where nothing is connected
	localparam int OMAP[4][8] = '{'{-1, 17, 16, 15, 14, 13, -1, 12},
		'{-1, -1, -1, 11, 10, 9, -1, 8}, '{-1, -1, -1, 11, 10, 7, 6, 5},
		'{-1, 4, 3, -1, 2, 1, -1, 0}};
	localparam int PX[4] = '{1, 5, 11, 19};
	rps_pin_select i_rps_pin_select (.clk(clk), .rstn(rstn), .axil_req(req), .axil_rsp(rsp),
		.sys_unlocked(sys_unlocked), .cfg_word3(cfg_word3), .periph_out(periph_out),
		.periph_in(periph_in), .pin_in(pin_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.analog_sel(analog_sel), .pin_out(pin_out), .pin_oe(pin_oe));
	rps_far_model i_rps_far_model (.ext_lvl(ext), .per_lvl(per), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in), .periph_out(periph_out));
	always #4 clk = ~clk;
	task automatic summarize;
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge clk);
		req.awaddr <= a;
		req.wdata <= d;
		req.awvalid <= 1;
		req.wvalid <= 1;
		req.bready <= 1;
		while (!(aw && w))
		begin
			@(posedge clk);
			if (!aw && rsp.awready === 1'b1)
			begin
				aw = 1;
				req.awvalid <= 0;
			end
			if (!w && rsp.wready === 1'b1)
			begin
				w = 1;
				req.wvalid <= 0;
			end
		end
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		req.bready <= 0;
		chk({30'h0, rsp.bresp}, {30'h0, e});
	endtask
	task automatic rd(input logic [31:0] a, d, input logic [1:0] e);
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1;
		req.rready <= 1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 0;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		req.rready <= 0;
		chk({30'h0, rsp.rresp}, {30'h0, e});
		if (e == `RPS_RESP_OKAY)
			chk(rsp.rdata, d);
	endtask
	task automatic do_rst(input logic [31:0] cw);
		cfg_word3 <= cw;
		rstn <= 0;
		repeat (5) @(posedge clk);
		rstn <= 1;
		repeat (4) @(posedge clk);
	endtask
	// Inputs assigned before use; reserved codes read back inactive
	task automatic t_in;
		for (int g = 0; g < 4; g++)
			for (int c = 0; c < 16; c++)
			begin
				if (c > 8 && c < 15)
					continue;
				wr(PX[g] * 4, c, `RPS_RESP_OKAY);
				ext <= (c < 8) ? 32'h1 << (g * 8 + c) : 32'hFFFF_FFFF;
				repeat (4) @(posedge clk);
				chk({31'h0, periph_in[PX[g]]}, {31'h0, c < 8});
				ext <= ~ext;
				repeat (4) @(posedge clk);
				chk({31'h0, periph_in[PX[g]]}, 32'h0);
			end
	endtask
	// Remapped outputs override port drive; code 0 leaves the port
	task automatic t_out;
		for (int g = 0; g < 4; g++)
			for (int c = 0; c < 8; c++)
			begin
				if (c != 0 && OMAP[g][c] < 0)
					continue;
				wr(32'h100 + g * 32, c, `RPS_RESP_OKAY);
				per <= (c == 0) ? '0 : rps_periph_out_t'(18'h1 << OMAP[g][c]);
				gpio_out <= 32'hFFFF_FFFF;
				repeat (2) @(posedge clk);
				chk({31'h0, pin_out[g * 8]}, 32'h1);
				chk({31'h0, pin_oe[g * 8]}, {31'h0, c != 0});
				per <= ~per;
				gpio_out <= (c == 0) ? 32'h0 : 32'hFFFF_FFFF;
				repeat (2) @(posedge clk);
				chk({31'h0, pin_out[g * 8]}, 32'h0);
			end
		analog_sel <= 32'h0100_0000;
		gpio_oe <= 32'h0000_0004;
		repeat (2) @(posedge clk);
		chk({31'h0, pin_out[24]}, 32'h1);
		chk({31'h0, pin_oe[24]}, 32'h0);
		chk({31'h0, pin_oe[2]}, 32'h1);
		analog_sel <= 32'h0;
		gpio_oe <= 32'h0;
		rd(32'h160, 32'h7, `RPS_RESP_OKAY);
	endtask
	// Lock bit, single-session option and reset release
	task automatic t_lock;
		wr(32'h200, 32'h2000, `RPS_RESP_OKAY);
		rd(32'h200, 32'h0, `RPS_RESP_OKAY);
		sys_unlocked <= 1;
		wr(32'h200, 32'h2000, `RPS_RESP_OKAY);
		rd(32'h200, 32'h2000, `RPS_RESP_OKAY);
		wr(32'h4, 32'h2, `RPS_RESP_OKAY);
		rd(32'h4, 32'hF, `RPS_RESP_OKAY);
		wr(32'h200, 32'h0, `RPS_RESP_OKAY);
		rd(32'h200, 32'h2000, `RPS_RESP_OKAY);
		rd(32'h204, 32'h2000_0000, `RPS_RESP_OKAY);
		do_rst(32'h0);
		rd(32'h200, 32'h0, `RPS_RESP_OKAY);
		rd(32'h100, 32'h0, `RPS_RESP_OKAY);
		wr(32'h200, 32'h2000, `RPS_RESP_OKAY);
		wr(32'h200, 32'h0, `RPS_RESP_OKAY);
		rd(32'h200, 32'h0, `RPS_RESP_OKAY);
		wr(32'h4, 32'h2, `RPS_RESP_OKAY);
		rd(32'h4, 32'h2, `RPS_RESP_OKAY);
		sys_unlocked <= 0;
	endtask
	// Unmapped places, including pin 2, one of the two pins with no output select
	task automatic t_err;
		wr(32'h300, 32'h1, `RPS_RESP_SLVERR);
		rd(32'h300, 32'h0, `RPS_RESP_SLVERR);
		wr(32'h108, 32'h1, `RPS_RESP_SLVERR);
	endtask
	initial
	begin
		clk = 0;
		rstn = 1;
		req = '0;
		req.wstrb = 4'hF;
		sys_unlocked = 0;
		cfg_word3 = 32'h2000_0000;
		ext = 32'h0;
		per = '0;
		gpio_out = 32'h0;
		gpio_oe = 32'h0;
		analog_sel = 32'h0;
		mismatches = 0;
		tests_run = 0;
		cyc = 0;
		do_rst(32'h2000_0000);
		t_in();
		t_out();
		t_err();
		t_lock();
		summarize();
	end
endmodule
bind rps_pin_select rps_pin_select_checker i_rps_pin_select_checker (.clk(clk), .rstn(rstn),
	.axil_req(axil_req), .axil_rsp(axil_rsp), .gpio_out(gpio_out),
	.analog_sel(analog_sel), .pin_out(pin_out));
`default_nettype wire
